/* File: flash_array_read_access.sv */
`include "flash_read_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_array_read_access
  import flash_read_pkg::*;
#(
  parameter int          BANK_AW = 15,
  parameter int          SECTORS = 32,
  parameter logic [31:0] PERIPH_BASE = 32'h4000_0000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        boot_flash_valid,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        control_register_move_instruction_wr,
  input  wire logic [31:0] control_register_move_instruction_data,
  input  wire logic        core_req,
  input  wire logic [31:0] core_addr,
  input  wire logic        core_super,
  input  wire logic        core_instr,
  input  wire logic        bd_req,
  input  wire logic        bd_write,
  input  wire logic        bd_erase,
  input  wire logic [31:0] bd_addr,
  input  wire logic [31:0] bd_wdata,
  output logic             rd_valid,
  output logic [31:0]      rd_data,
  output logic             rd_err,
  output logic             prog_reject
);
  localparam int SW = $clog2(SECTORS);

  typedef struct packed {
    word_t       fbar;
    logic        latsel;
    word_t       prot;
    word_t       sacc;
    word_t       dacc;
    word_t       sec;
    word_t       busy;
    rd_state_e   st;
    logic [2:0]  wait_cnt;
    logic [17:0] last_addr;
    logic        streaming;
    logic        pend_bd;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rd_valid;
    logic [31:0] rd_data;
    logic        rd_err;
    logic        prog_reject;
    logic        cfg_loaded;
  } state_s;

  state_s s_q, s_d;

  logic        cfg_req, cfg_done;
  logic [2:0]  cfg_idx;
  logic [17:0] cfg_off;
  logic [31:0] rdata_even, rdata_odd, word_sel;
  logic [17:0] acc_off;
  logic [BANK_AW-1:0] bank_addr;
  logic        core_hit, bd_hit, sector_ok, bd_rd, bd_pw;
  logic [SW-1:0] sec_idx;

  always_comb
  begin
    unique case (cfg_idx)
      3'h0:    cfg_off = `FR_CFG_KEY_LO;
      3'h1:    cfg_off = `FR_CFG_KEY_HI;
      3'h2:    cfg_off = `FR_CFG_PROT;
      3'h3:    cfg_off = `FR_CFG_SACC;
      3'h4:    cfg_off = `FR_CFG_DACC;
      3'h5:    cfg_off = `FR_CFG_SEC;
      default: cfg_off = `FR_CFG_KEY_LO;
    endcase
  end

  // Core decode: valid bit, 512K-aligned base, within capacity
  assign core_hit = core_req && s_q.fbar[`FR_FBAR_V_BIT] && cfg_done &&
                    (core_addr[31:`FR_FBAR_BA_LSB] == s_q.fbar[31:`FR_FBAR_BA_LSB]) &&
                    (core_addr[`FR_FBAR_BA_LSB-1:0] < 19'(`FR_ARRAY_BYTES));
  assign bd_hit   = bd_req && cfg_done &&
                    (bd_addr - (PERIPH_BASE + `FR_BACKDOOR_OFS)) < `FR_ARRAY_BYTES;
  assign bd_rd    = bd_hit && !bd_write && !bd_erase;
  assign bd_pw    = bd_hit && (bd_write || bd_erase);
  assign acc_off  = !cfg_done ? cfg_off :
                    bd_hit ? 18'(bd_addr - (PERIPH_BASE + `FR_BACKDOOR_OFS)) : core_addr[17:0];
  // Byte address bit 2 picks the bank
  assign bank_addr = acc_off[BANK_AW+2:3];
  assign sec_idx   = acc_off[17 -: SW];
  // Set bit in an access word inhibits that class
  assign sector_ok = !(core_super ? s_q.sacc[sec_idx] : 1'b0) &&
                     !(!core_instr ? s_q.dacc[sec_idx] : 1'b0);
  assign word_sel  = s_q.last_addr[2] ? rdata_odd : rdata_even;

  logic wr_even, wr_odd, er_even, er_odd, prog_ok;
  assign prog_ok = bd_pw && !s_q.prot[sec_idx];
  assign wr_even = prog_ok && bd_write && !acc_off[2];
  assign wr_odd  = prog_ok && bd_write &&  acc_off[2];
  assign er_even = prog_ok && bd_erase && !acc_off[2];
  assign er_odd  = prog_ok && bd_erase &&  acc_off[2];

  flash_bank #(.AW(BANK_AW)) u_even (
    .pclk     (pclk),
    .wr_en    (wr_even),
    .erase_en (er_even),
    .addr     (bank_addr),
    .wdata    (bd_wdata),
    .rdata    (rdata_even)
  );
  flash_bank #(.AW(BANK_AW)) u_odd (
    .pclk     (pclk),
    .wr_en    (wr_odd),
    .erase_en (er_odd),
    .addr     (bank_addr),
    .wdata    (bd_wdata),
    .rdata    (rdata_odd)
  );

  flash_cfg_loader u_cfg (
    .pclk     (pclk),
    .presetn  (presetn),
    .word_in  (word_sel),
    .word_vld (cfg_req && s_q.st == RD_DONE),
    .idx      (cfg_idx),
    .req      (cfg_req),
    .done     (cfg_done)
  );

  always_comb
  begin
    logic        apb_acc;
    logic        blocked;
    logic [2:0]  lat;
    apb_acc = psel && penable && !s_q.pready;
    blocked = s_q.busy[sec_idx];
    lat     = s_q.latsel ? 3'h2 : 3'h1;
    s_d = s_q;
    s_d.pready      = 1'b0;
    s_d.pslverr     = 1'b0;
    s_d.rd_valid    = 1'b0;
    s_d.rd_err      = 1'b0;
    s_d.prog_reject = bd_pw && s_q.prot[sec_idx];

    // Loader drops loaded protect, access and security words into the shadow registers; key words are not kept
    if (cfg_req && s_q.st == RD_DONE)
    begin
      unique case (cfg_idx)
        3'h2:    s_d.prot = word_sel;
        3'h3:    s_d.sacc = word_sel;
        3'h4:    s_d.dacc = word_sel;
        3'h5:    s_d.sec  = word_sel;
        default: ;
      endcase
    end

    // Latency 0 = one cycle, 1 = two cycles; backdoor adds two more
    if (bd_rd)
      lat = lat + 3'(`FR_BACKDOOR_EXTRA);
    unique case (s_q.st)
      RD_IDLE:
      begin
        // Old request still stands while its answer is out; never take it twice
        if ((core_hit || bd_rd || cfg_req) && !(blocked && cfg_done) && !s_q.rd_valid)
        begin
          s_d.last_addr = acc_off;
          s_d.pend_bd   = bd_rd;
          // Next sequential word overlaps in the other bank
          if (s_q.streaming && !bd_rd && acc_off == s_q.last_addr + 18'h4)
            s_d.wait_cnt = 3'h0;
          else
            s_d.wait_cnt = lat - 3'h1;
          s_d.st = (s_d.wait_cnt == 3'h0) ? RD_DONE : RD_WAIT;
        end
        else if (core_req && !core_hit && !bd_req)
          s_d.streaming = 1'b0;
      end
      RD_WAIT:
      begin
        s_d.wait_cnt = s_q.wait_cnt - 3'h1;
        if (s_q.wait_cnt == 3'h1)
          s_d.st = RD_DONE;
      end
      RD_DONE:
      begin
        s_d.st = RD_IDLE;
        if (cfg_done)
        begin
          s_d.rd_valid  = 1'b1;
          s_d.rd_err    = !s_q.pend_bd && !sector_ok;
          s_d.rd_data   = (!s_q.pend_bd && !sector_ok) ? 32'h0 : word_sel;
          s_d.streaming = !s_q.pend_bd && s_q.latsel;
        end
      end
    endcase

    // Base register: core move instruction writes, never reads
    if (control_register_move_instruction_wr)
      s_d.fbar = control_register_move_instruction_data & `FR_FBAR_MASK;

    if (apb_acc)
    begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0;
      unique case (paddr)
        `FR_OFS_FBAR:
        begin
          if (pwrite)
            s_d.fbar = pwdata & `FR_FBAR_MASK;
          else
            s_d.prdata = s_q.fbar & `FR_FBAR_MASK;
        end
        `FR_OFS_LATSEL:
        begin
          s_d.prdata = {31'h0, s_q.latsel};
          if (pwrite)
            s_d.latsel = pwdata[0];
        end
        `FR_OFS_PROT:
        begin
          s_d.prdata = s_q.prot;
          if (pwrite)
            s_d.prot = pwdata;
        end
        `FR_OFS_SACC:
        begin
          s_d.prdata = s_q.sacc;
          if (pwrite)
            s_d.sacc = pwdata;
        end
        `FR_OFS_DACC:
        begin
          s_d.prdata = s_q.dacc;
          if (pwrite)
            s_d.dacc = pwdata;
        end
        `FR_OFS_SEC:    s_d.prdata = s_q.sec;
        `FR_OFS_BUSY:
        begin
          s_d.prdata = s_q.busy;
          if (pwrite)
            s_d.busy = pwdata;
        end
        `FR_OFS_STATUS: s_d.prdata = {29'h0, s_q.streaming, s_q.st != RD_IDLE, cfg_done};
        default:        s_d.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q        <= '0;
      s_q.latsel <= `FR_LATSEL_RESET;
      s_q.prot   <= `FR_CFG_RESET;
      s_q.sacc   <= `FR_CFG_RESET;
      s_q.dacc   <= `FR_CFG_RESET;
      s_q.sec    <= `FR_CFG_RESET;
      s_q.st     <= RD_IDLE;
    end
    else
    begin
      s_q <= s_d;
      // Strap caught on the first edge after release
      if (!s_q.cfg_loaded)
      begin
        s_q.cfg_loaded <= 1'b1;
        s_q.fbar[`FR_FBAR_V_BIT] <= boot_flash_valid;
      end
    end
  end

  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign rd_valid    = s_q.rd_valid;
  assign rd_data     = s_q.rd_data;
  assign rd_err      = s_q.rd_err;
  assign prog_reject = s_q.prog_reject;

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready) else $error("APB not answered");
  a_hit_needs_valid: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == RD_IDLE && cfg_done && !s_q.fbar[`FR_FBAR_V_BIT] && !bd_req |=> s_q.st == RD_IDLE)
    else $error("read started without valid base");
  a_bd_latency: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == RD_IDLE && s_d.st == RD_WAIT && bd_rd && s_q.latsel |=> s_q.wait_cnt == 3'h3)
    else $error("backdoor latency wrong");
  a_prot_reject: assert property (@(posedge pclk) disable iff (!presetn)
    bd_pw && s_q.prot[sec_idx] |=> prog_reject) else $error("protect miss");
  a_prog_allowed: assert property (@(posedge pclk) disable iff (!presetn)
    bd_pw && !s_q.prot[sec_idx] |=> !prog_reject) else $error("unprotected write rejected");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.fbar & ~`FR_FBAR_MASK) == 32'h0) else $error("reserved bit set");
  a_block_read: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == RD_IDLE && cfg_done && s_q.busy[sec_idx] |=> s_q.st == RD_IDLE)
    else $error("read of busy block");
  a_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == RD_IDLE && core_hit && !bd_hit && !s_q.latsel && !s_q.busy[sec_idx] && !rd_valid
    |=> s_q.st == RD_DONE)
    else $error("single cycle latency wrong");
  a_stream_fast: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == RD_IDLE && core_hit && !bd_hit && !rd_valid && !s_q.busy[sec_idx] && s_q.streaming &&
    acc_off == s_q.last_addr + 18'h4 |=> s_q.st == RD_DONE)
    else $error("sequential read not streamed");
  a_err_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_err |-> rd_valid && rd_data == 32'h0) else $error("inhibited read leaked data");
  a_cfg_first: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_done |-> !rd_valid) else $error("read answered before configuration");
  a_answer_once: assert property (@(posedge pclk) disable iff (!presetn)
    rd_valid |=> !rd_valid) else $error("answer stood two cycles");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error without ready");
  c_read: cover property (@(posedge pclk) rd_valid);
  c_stream: cover property (@(posedge pclk) rd_valid ##3 rd_valid);
  c_reject: cover property (@(posedge pclk) prog_reject);
  c_backdoor: cover property (@(posedge pclk) rd_valid && s_q.pend_bd);
  c_blocked: cover property (@(posedge pclk) s_q.st == RD_IDLE && core_hit && s_q.busy[sec_idx]);
endmodule : flash_array_read_access
`default_nettype wire

/* File: flash_read_defs.svh */
`ifndef FLASH_READ_DEFS_SVH
`define FLASH_READ_DEFS_SVH

// APB register byte addresses
`define FR_OFS_FBAR        12'h000
`define FR_OFS_LATSEL      12'h004
`define FR_OFS_PROT        12'h008
`define FR_OFS_SACC        12'h00C
`define FR_OFS_DACC        12'h010
`define FR_OFS_SEC         12'h014
`define FR_OFS_BUSY        12'h018
`define FR_OFS_STATUS      12'h01C
// Base-address register fields
`define FR_FBAR_BA_LSB     19
`define FR_FBAR_WP_BIT     8
`define FR_FBAR_AS_LSB     1
`define FR_FBAR_V_BIT      0
`define FR_FBAR_MASK       32'hFFF8_013F
// Configuration field offsets inside the array
`define FR_CFG_KEY_LO      18'h00400
`define FR_CFG_KEY_HI      18'h00404
`define FR_CFG_PROT        18'h00408
`define FR_CFG_SACC        18'h0040C
`define FR_CFG_DACC        18'h00410
`define FR_CFG_SEC         18'h00414
`define FR_CFG_WORDS       6
`define FR_CFG_RESET       32'hFFFF_FFFF
// Array geometry, backdoor mapping, erased value and latency reset
`define FR_ARRAY_BYTES     32'h0004_0000
`define FR_BACKDOOR_OFS    32'h0400_0000
`define FR_BACKDOOR_EXTRA  2
`define FR_ERASED_WORD     32'hFFFF_FFFF
`define FR_LATSEL_RESET    1'b1

`endif

/* File: flash_read_pkg.sv */
package flash_read_pkg;
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_WAIT,
    RD_DONE
  } rd_state_e;
  typedef logic [31:0] word_t;
endpackage : flash_read_pkg

/* File: flash_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// One interleaved physical block; erased cells read ones
module flash_bank #(
  parameter int AW = 15
) (
  input  wire logic          pclk,
  input  wire logic          wr_en,
  input  wire logic          erase_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [31:0]   wdata,
  output logic [31:0]        rdata
);
  // Array starts erased, so words never programmed read all ones
  logic [31:0] mem [2**AW] = '{default: 32'hFFFF_FFFF};

  // Programming only clears bits; erase sets the addressed word back
  always_ff @(posedge pclk)
  begin
    if (erase_en)
      mem[addr] <= 32'hFFFF_FFFF;
    else if (wr_en)
      mem[addr] <= mem[addr] & wdata;
    rdata <= mem[addr];
  end
endmodule : flash_bank
`default_nettype wire

/* File: flash_cfg_loader.sv */
`include "flash_read_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// Walks the configuration words after reset
module flash_cfg_loader
  import flash_read_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] word_in,
  input  wire logic        word_vld,
  output logic [2:0]       idx,
  output logic             req,
  output logic             done
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx  <= 3'h0;
      req  <= 1'b0;
      done <= 1'b0;
    end
    else if (!done)
    begin
      req <= !word_vld;
      if (word_vld)
      begin
        if (idx == 3'(`FR_CFG_WORDS - 1))
          done <= 1'b1;
        else
          idx <= idx + 3'h1;
      end
    end
    else
      req <= 1'b0;
  end
endmodule : flash_cfg_loader
`default_nettype wire

/* File: core_model.sv */
`include "flash_read_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// Core and backdoor masters, one transfer at a time
module core_model
  import flash_read_pkg::*;
#(
  parameter logic [31:0] PERIPH_BASE = 32'h4000_0000
) (
  input  wire logic   pclk,
  input  wire logic   rd_valid,
  input  wire word_t  rd_data,
  input  wire logic   rd_err,
  output logic        core_req,
  output word_t       core_addr,
  output logic        core_super,
  output logic        core_instr,
  output logic        bd_req,
  output logic        bd_write,
  output logic        bd_erase,
  output word_t       bd_addr,
  output word_t       bd_wdata
);
  initial
  begin
    {core_req, core_super, core_instr, bd_req, bd_write, bd_erase} = 6'h00;
    {core_addr, bd_addr, bd_wdata} = {32'h0, 32'h0, 32'h0};
  end
  // Held until answered or until n reaches 60; hold keeps the request up for a streamed follow-on
  task automatic rd(input logic bd, input word_t a, input logic sup, input logic ins, input logic hold,
                    output word_t d, output logic e, output int n);
    n = 0;
    core_super <= sup;
    core_instr <= ins;
    if (bd)
      {bd_req, bd_addr} <= {1'b1, PERIPH_BASE + `FR_BACKDOOR_OFS + a};
    else
      {core_req, core_addr} <= {1'b1, a};
    // Answer is taken at the rising edge that samples rd_valid high
    forever
    begin
      @(posedge pclk);
      if (rd_valid === 1'b1 || n == 60)
        break;
      n++;
    end
    d = rd_data;
    e = rd_err;
    // Released address shows garbage, not the last value
    if (!hold)
      {core_req, bd_req, core_addr, bd_addr} <= {2'b00, ~core_addr, ~bd_addr};
  endtask : rd
  task automatic wr(input word_t a, input word_t dat, input logic er);
    {bd_req, bd_write, bd_erase, bd_wdata} <= {1'b1, ~er, er, dat};
    bd_addr <= PERIPH_BASE + `FR_BACKDOOR_OFS + a;
    @(posedge pclk);
    {bd_req, bd_write, bd_erase, bd_wdata, bd_addr} <= {3'b000, ~dat, ~bd_addr};
    @(posedge pclk);
  endtask : wr
endmodule : core_model
`default_nettype wire

/* File: flash_array_read_access_bench.sv */
`include "flash_read_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_array_read_access_bench;
  import flash_read_pkg::*;
  logic        pclk, presetn, boot_flash_valid, psel, penable, pwrite, pready, pslverr, control_register_move_instruction_wr;
  logic        core_req, core_super, core_instr, bd_req, bd_write, bd_erase, rd_valid, rd_err, prog_reject;
  logic [11:0] paddr;
  word_t       pwdata, prdata, control_register_move_instruction_data, core_addr, bd_addr, bd_wdata, rd_data, d;
  logic        e;
  int          error_cnt, total_checks, cyc, rej_cnt, n, n1, k;
  logic [4:0]  acc_tab [3] = '{5'b10111, 5'b10000, 5'b01001};
  flash_array_read_access i_flash_array_read_access (.pclk, .presetn, .boot_flash_valid, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .control_register_move_instruction_wr, .control_register_move_instruction_data, .core_req, .core_addr,
    .core_super, .core_instr, .bd_req, .bd_write, .bd_erase, .bd_addr, .bd_wdata, .rd_valid, .rd_data,
    .rd_err, .prog_reject);
  core_model i_core_model (.pclk, .rd_valid, .rd_data, .rd_err, .core_req, .core_addr, .core_super,
    .core_instr, .bd_req, .bd_write, .bd_erase, .bd_addr, .bd_wdata);
  initial
  begin
    pclk = 1'b0;
    forever
      #2 pclk = ~pclk;
  end
  // Timeout ceiling well above the few hundred cycles the tests need
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    rej_cnt <= rej_cnt + (prog_reject === 1'b1);
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic check(input string what, input word_t seen, input word_t exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input word_t wd);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until pready is seen at a rising edge
    forever
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    d = prdata;
    e = pslverr;
    {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~wd};
    @(posedge pclk);
  endtask : apb
  task automatic control_register_move_instruction(input word_t v);
    {control_register_move_instruction_wr, control_register_move_instruction_data} <= {1'b1, v};
    @(posedge pclk);
    {control_register_move_instruction_wr, control_register_move_instruction_data} <= {1'b0, ~v};
    @(posedge pclk);
  endtask : control_register_move_instruction
  task automatic do_reset(input logic v);
    {presetn, boot_flash_valid} <= {1'b0, v};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    d = 32'h0;
    // Reads are held off until the configuration walk finishes
    for (k = 0; k < 40 && d[0] !== 1'b1; k++)
      apb(1'b0, `FR_OFS_STATUS, 32'h0);
    apb(1'b0, `FR_OFS_FBAR, 32'h0);
    check("valid bit", {31'h0, d[0]}, {31'h0, v});
  endtask : do_reset
  initial
  begin
    {presetn, boot_flash_valid, psel, penable, pwrite, control_register_move_instruction_wr} = 6'h00;
    {paddr, pwdata, control_register_move_instruction_data, d} = {12'h0, 32'h0, 32'h0, 32'h0};
    {error_cnt, total_checks, cyc, rej_cnt} = {32'h0, 32'h0, 32'h0, 32'h0};
    do_reset(1'b1);
    apb(1'b0, `FR_OFS_LATSEL, 32'h0);
    check("latency select", d, 32'h1);
    for (k = 0; k < 4; k++)
    begin
      apb(1'b0, 12'(`FR_OFS_PROT + 4 * k), 32'h0);
      check("config word", d, `FR_CFG_RESET);
    end
    apb(1'b1, `FR_OFS_SEC, 32'h0);
    apb(1'b0, `FR_OFS_SEC, 32'h0);
    check("security read only", d, `FR_CFG_RESET);
    $display("test reset done");
    apb(1'b1, `FR_OFS_FBAR, 32'hFFFF_FFFF);
    apb(1'b0, `FR_OFS_FBAR, 32'h0);
    check("base debug rw", d, `FR_FBAR_MASK);
    control_register_move_instruction(32'h0000_0001);
    apb(1'b0, `FR_OFS_FBAR, 32'h0);
    check("base core write", d, 32'h0000_0001);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    for (k = 0; k < 3; k++)
      apb(1'b1, 12'(`FR_OFS_PROT + 4 * k), 32'h0);
    $display("test base register done");
    i_core_model.rd(1'b0, 32'h0, 1'b1, 1'b0, 1'b0, d, e, n);
    check("erased word", d, `FR_ERASED_WORD);
    check("two cycle latency", n, 3);
    i_core_model.wr(32'h100, 32'h1234_5678, 1'b0);
    i_core_model.wr(32'h104, 32'hA5A5_0F0F, 1'b0);
    i_core_model.wr(32'h104, 32'hFFFF_00FF, 1'b0);
    i_core_model.rd(1'b0, 32'h100, 1'b1, 1'b0, 1'b1, d, e, n1);
    check("even bank", d, 32'h1234_5678);
    i_core_model.rd(1'b0, 32'h104, 1'b1, 1'b0, 1'b0, d, e, n);
    check("odd bank and", d, 32'hA5A5_000F);
    check("streamed faster", {31'h0, n < n1}, 32'h1);
    i_core_model.wr(32'h104, 32'h0, 1'b1);
    i_core_model.rd(1'b0, 32'h104, 1'b1, 1'b0, 1'b0, d, e, n);
    check("erase to ones", d, `FR_ERASED_WORD);
    i_core_model.rd(1'b1, 32'h100, 1'b1, 1'b0, 1'b0, d, e, n);
    check("backdoor data", d, 32'h1234_5678);
    check("backdoor latency", n, 3 + `FR_BACKDOOR_EXTRA);
    apb(1'b1, `FR_OFS_LATSEL, 32'h0);
    i_core_model.rd(1'b0, 32'h200, 1'b1, 1'b0, 1'b0, d, e, n);
    check("one cycle latency", n, 2);
    $display("test read path done");
    apb(1'b1, `FR_OFS_BUSY, 32'h1);
    fork
      i_core_model.rd(1'b0, 32'h100, 1'b1, 1'b0, 1'b0, d, e, n);
      begin
        repeat (10) @(posedge pclk);
        apb(1'b1, `FR_OFS_BUSY, 32'h0);
      end
    join
    check("busy wait", {31'h0, n > 10 && n < 60}, 32'h1);
    check("busy data", d, 32'h1234_5678);
    apb(1'b1, `FR_OFS_PROT, 32'h1);
    i_core_model.wr(32'h100, 32'h0, 1'b0);
    repeat (4) @(posedge pclk);
    check("reject pulse", rej_cnt, 1);
    i_core_model.rd(1'b0, 32'h100, 1'b1, 1'b0, 1'b0, d, e, n);
    check("protected kept", d, 32'h1234_5678);
    for (k = 0; k < 3; k++)
    begin
      apb(1'b1, `FR_OFS_SACC, {31'h0, acc_tab[k][4]});
      apb(1'b1, `FR_OFS_DACC, {31'h0, acc_tab[k][3]});
      i_core_model.rd(1'b0, 32'h100, acc_tab[k][2], acc_tab[k][1], 1'b0, d, e, n);
      check("access error", {31'h0, e}, {31'h0, acc_tab[k][0]});
      check("access data", d, acc_tab[k][0] ? 32'h0 : 32'h1234_5678);
    end
    $display("test protection done");
    control_register_move_instruction(32'h0008_0001);
    // Instruction fetch, since data reads of sector 0 are still inhibited
    i_core_model.rd(1'b0, 32'h0008_0100, 1'b1, 1'b1, 1'b0, d, e, n);
    check("moved base", d, 32'h1234_5678);
    i_core_model.rd(1'b0, 32'h0000_0100, 1'b1, 1'b0, 1'b0, d, e, n);
    check("outside window", n, 60);
    control_register_move_instruction(32'h0008_0000);
    i_core_model.rd(1'b0, 32'h0008_0100, 1'b1, 1'b0, 1'b0, d, e, n);
    check("invalid base", n, 60);
    do_reset(1'b0);
    $display("test mapping done");
    close_out();
  end
endmodule : flash_array_read_access_bench
`default_nettype wire
